// *** pkg/adcc_pkg.sv ***
// Package for the converter control block: register map, field layout,
// reset values, timing counts and the carrier types.
// Assumes a 32-bit AXI4-Lite register bus and an analog core with a DAC and comparator.
`default_nettype none

package adcc_pkg;

    // Register indexes; byte address is four times the index
    localparam logic [9:0] CSR_IDX = 10'h070;      // converter_control_status
    localparam logic [9:0] RES_HI_IDX = 10'h071;   // conversion_result_high
    localparam logic [9:0] RES_LO_IDX = 10'h072;   // conversion_result_low
    localparam logic [9:0] INT_STAT_IDX = 10'h073; // Sticky event status
    localparam logic [9:0] INT_MASK_IDX = 10'h074; // Event mask

    // Control/status field positions
    localparam int CSR_DONE_BIT = 7;
    localparam int CSR_SPEED_BIT = 6;
    localparam int CSR_ON_BIT = 5;
    localparam int CSR_CH_LSB = 0;

    // Reset values
    localparam logic [7:0] CSR_RESET = 8'h00;
    localparam logic [9:0] RESULT_RESET = 10'h000;
    localparam logic [0:0] INT_RESET = 1'h0;

    // Converter width and channel count
    localparam int RES_W = 10;
    localparam int CH_W = 4;

    // Timing counts in converter clocks; the fast divider is 2, the slow one 4
    localparam int SAMPLE_ADC_CLKS = 3;
    localparam int BIT_ADC_CLKS = 2;
    localparam logic [7:0] DIV_FAST = 8'h02;
    localparam logic [7:0] DIV_SLOW = 8'h04;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Software view of the control/status register
    typedef struct packed {
        logic speed;             // Fast converter clock
        logic on;                // converter_on
        logic [CH_W-1:0] chan;   // input_channel_bits
    } adcc_csr_t;

    // Signals to the analog core
    typedef struct packed {
        logic enable;            // Power the core
        logic [CH_W-1:0] chan;   // Multiplexer select
        logic sample;            // Sample-and-hold tracking
        logic [RES_W-1:0] code;  // Trial DAC code
    } adcc_core_t;

    // Sequencer states, Gray along sample, convert, done
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONVERT = 2'b11,
        ST_DONE = 2'b10
    } adcc_state_t;

endpackage : adcc_pkg

`default_nettype wire

// *** design/adcc_sync.sv ***
// Two-flop synchroniser for a level arriving from outside the clock domain.
// Assumes the input is a slowly changing level such as a comparator output.
`timescale 1ns/1ps
`default_nettype none

module adcc_sync (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_reg; // First stage, read only by the second

    // Two stages, cleared under reset
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : adcc_sync

`default_nettype wire

// *** design/adcc_sar.sv ***
// Successive approximation register: one trial bit per step, MSB first.
// Assumes the caller waits long enough after each step for the comparator to settle.
`timescale 1ns/1ps
`default_nettype none

module adcc_sar
    import adcc_pkg::*;
#(
    parameter int W = RES_W
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic start,     // Begin a new approximation
    input wire logic step,      // Decide the current bit
    input wire logic above,     // Input is above the trial level
    output logic [W-1:0] code,  // Trial code, final after the last step
    output logic last           // Current bit is the LSB
);
    logic [W-1:0] mask_reg; // One-hot bit under trial
    logic all_up_reg;       // Every decision so far kept the bit
    logic all_down_reg;     // Every decision so far dropped the bit

    assign last = mask_reg[0];

    // Trial code: keep or drop the bit, then try the next lower one
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            code <= '0;
            mask_reg <= '0;
        end else if (start) begin
            code <= W'(1) << (W - 1);
            mask_reg <= W'(1) << (W - 1);
        end else if (step && mask_reg != '0) begin
            // Binary search gives a monotonic code (see RQ4)
            code <= (above ? code : (code & ~mask_reg)) | (mask_reg >> 1); // see RQ1
            mask_reg <= mask_reg >> 1;
        end
    end

    // Decision history, used to check the rails
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            all_up_reg <= 1'b0;
            all_down_reg <= 1'b0;
        end else if (start) begin
            all_up_reg <= 1'b1;
            all_down_reg <= 1'b1;
        end else if (step) begin
            all_up_reg <= all_up_reg & above;
            all_down_reg <= all_down_reg & ~above;
        end
    end

    // Above the high reference every bit is kept: full scale
    a_full_scale_code: assert property (@(posedge ref_clk) disable iff (reset) // see RQ2
        (step && last && all_up_reg && above) |=> (code == {W{1'b1}}))
        else $error("full scale not reached");

    // Below the low reference every bit is dropped: zero
    a_zero_scale_code: assert property (@(posedge ref_clk) disable iff (reset) // see RQ3
        (step && last && all_down_reg && !above) |=> (code == '0))
        else $error("zero scale not reached");
endmodule : adcc_sar

`default_nettype wire

// *** design/adcc_top.sv ***
// Converter control: AXI4-Lite registers, conversion sequencer and analog core drive.
// Assumes a 50 MHz ref_clk, an asynchronous comparator output from the analog core,
// and an AXI4-Lite master that keeps one write and one read under way at a time.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RQ1: Ten-bit successive approximation, sixteen input channels.
// RQ2: Above high reference result is full scale.
// RQ3: Below low reference result is zero.
// RQ4: Codes are monotonic in the input.
// RQ5: Turning on starts continuous conversions.
// RQ6: Each completion sets flag, loads results.
// RQ7: Reading high result clears the flag.
// RQ8: Every completion overwrites both result registers.
// RQ9: Software reads low then high promptly.
// RQ10: Software may read only the high result.
// RQ11: Channel change aborts, clears flag, restarts.
// RQ12: Four-bit channel field drives the multiplexer.
// RQ13: Software configures analog pins as plain inputs.
// RQ14: Turning off stops any conversion.
// RQ15: Any control register write clears flag.
// RQ16: High holds bits nine-two; low holds one-zero.
// RQ17: Conversion timed by parameterised cycle counts.
// RQ18: Reset: off, flag clear, channel zero.
module adcc_top
    import adcc_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int SAMPLE_CLKS = SAMPLE_ADC_CLKS,
    parameter int BIT_CLKS = BIT_ADC_CLKS
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic cmp_above,
    output adcc_core_t core_out,
    output logic irq
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    // Write channel holding registers
    logic [ADDR_W-1:0] awaddr_reg;
    logic aw_full_reg;
    logic [7:0] wdata_reg;
    logic wstrb0_reg;
    logic w_full_reg;
    // Register contents
    adcc_csr_t csr_reg;
    logic done_reg;                  // conversion_done_flag
    logic [RES_W-1:0] result_reg;    // Last completed result
    logic int_stat_reg;              // Sticky completion event
    logic int_mask_reg;              // Completion event enable
    // Sequencer
    adcc_state_t state_reg;
    logic [7:0] tick_reg;            // Cycles left in the current phase
    logic restart_reg;               // Channel changed while running
    logic above_sync;                // Comparator after synchroniser
    logic [RES_W-1:0] sar_code;
    logic sar_last;
    logic core_enable_reg, core_sample_reg; // Core power and tracking, registered
    logic [CH_W-1:0] core_chan_reg; // Registered multiplexer select

    // Bus decode
    logic aw_hs, w_hs, ar_hs, do_write;
    logic [9:0] wr_idx, rd_idx;
    logic wr_map, csr_wr, stat_rd, hi_rd, chan_change;
    logic [7:0] rd_byte;
    logic rd_map;
    logic [7:0] div_len, sample_len, bit_len;
    logic conv_done, sar_start, sar_step;

    assign aw_hs = s_axi_awvalid && s_axi_awready;
    assign w_hs = s_axi_wvalid && s_axi_wready;
    assign ar_hs = s_axi_arvalid && s_axi_arready;
    assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
    assign wr_idx = 10'(awaddr_reg >> 2);
    assign rd_idx = 10'(s_axi_araddr >> 2);
    assign csr_wr = do_write && wstrb0_reg && wr_idx == CSR_IDX;
    assign hi_rd = ar_hs && rd_idx == RES_HI_IDX;
    assign stat_rd = ar_hs && rd_idx == INT_STAT_IDX;
    assign chan_change = csr_wr && wdata_reg[CH_W-1:0] != csr_reg.chan;
    assign conv_done = state_reg == ST_DONE;

    // Address map for writes: all five registers answer OKAY; writes to the result and status registers are ignored
    always_comb begin
        wr_map = (wr_idx == CSR_IDX) || (wr_idx == INT_MASK_IDX)
            || (wr_idx == RES_HI_IDX) || (wr_idx == RES_LO_IDX) || (wr_idx == INT_STAT_IDX);
    end

    // Read mux; reserved bits read zero
    always_comb begin
        rd_map = 1'b1;
        case (rd_idx)
            CSR_IDX: rd_byte = {done_reg, csr_reg.speed, csr_reg.on, 1'b0, csr_reg.chan};
            RES_HI_IDX: rd_byte = result_reg[9:2]; // see RQ16
            RES_LO_IDX: rd_byte = {6'h00, result_reg[1:0]}; // see RQ16
            INT_STAT_IDX: rd_byte = {7'h00, int_stat_reg};
            INT_MASK_IDX: rd_byte = {7'h00, int_mask_reg};
            default: begin
                rd_byte = 8'h00;
                rd_map = 1'b0;
            end
        endcase
    end

    // Write address channel: hold one address until the write completes
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            aw_full_reg <= 1'b0;
            awaddr_reg <= '0;
            s_axi_awready <= 1'b0;
        end else begin
            if (aw_hs) begin
                aw_full_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end else if (do_write) begin
                aw_full_reg <= 1'b0;
            end
            s_axi_awready <= !aw_full_reg && !aw_hs && !s_axi_bvalid;
        end
    end

    // Write data channel: hold one data beat until the write completes
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            w_full_reg <= 1'b0;
            wdata_reg <= 8'h00;
            wstrb0_reg <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            if (w_hs) begin
                w_full_reg <= 1'b1;
                wdata_reg <= s_axi_wdata[7:0];
                wstrb0_reg <= s_axi_wstrb[0];
            end else if (do_write) begin
                w_full_reg <= 1'b0;
            end
            s_axi_wready <= !w_full_reg && !w_hs && !s_axi_bvalid;
        end
    end

    // Write response, SLVERR for an unmapped address
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_map ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read channel: one read at a time, data registered
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (ar_hs) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rd_byte};
            s_axi_rresp <= rd_map ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // Control fields written by software; reset is off, channel zero
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            csr_reg <= {CSR_RESET[CSR_SPEED_BIT], CSR_RESET[CSR_ON_BIT], CSR_RESET[CSR_CH_LSB +: CH_W]}; // see RQ18
            int_mask_reg <= INT_RESET;
        end else if (do_write && wstrb0_reg) begin
            if (wr_idx == CSR_IDX) begin
                csr_reg.speed <= wdata_reg[CSR_SPEED_BIT];
                csr_reg.on <= wdata_reg[CSR_ON_BIT];
                csr_reg.chan <= wdata_reg[CSR_CH_LSB +: CH_W]; // see RQ12
            end else if (wr_idx == INT_MASK_IDX) begin
                int_mask_reg <= wdata_reg[0];
            end
        end
    end

    // Completion flag: set wins over the clears
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            done_reg <= CSR_RESET[CSR_DONE_BIT]; // see RQ18
        end else if (conv_done) begin
            done_reg <= 1'b1; // see RQ6
        end else if (hi_rd || csr_wr) begin
            done_reg <= 1'b0; // see RQ7 see RQ15 see RQ11
        end
    end

    // Result is not latched as a pair: every completion overwrites it
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            result_reg <= RESULT_RESET; // see RQ18
        end else if (conv_done) begin
            result_reg <= sar_code; // see RQ6 see RQ8
        end
    end

    // Sticky event status, cleared by reading it; a new event wins
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            int_stat_reg <= INT_RESET;
            irq <= 1'b0;
        end else begin
            if (conv_done) begin
                int_stat_reg <= 1'b1;
            end else if (stat_rd) begin
                int_stat_reg <= 1'b0;
            end
            irq <= int_stat_reg && int_mask_reg;
        end
    end

    // Phase lengths in CPU cycles from the selected converter clock
    always_comb begin
        div_len = csr_reg.speed ? DIV_FAST : DIV_SLOW;
        sample_len = 8'(SAMPLE_CLKS * div_len); // see RQ17
        bit_len = 8'(BIT_CLKS * div_len); // see RQ17
    end

    // Channel change while running requests an abort and restart
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            restart_reg <= 1'b0;
        end else begin
            restart_reg <= chan_change && csr_reg.on && wdata_reg[CSR_ON_BIT]; // see RQ11
        end
    end

    assign sar_start = state_reg == ST_SAMPLE && tick_reg == 8'h00 && !restart_reg && csr_reg.on;
    assign sar_step = state_reg == ST_CONVERT && tick_reg == 8'h00 && !restart_reg && csr_reg.on;

    // Sequencer: sample, approximate bit by bit, complete, repeat
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_reg <= ST_IDLE;
            tick_reg <= 8'h00;
        end else if (!csr_reg.on) begin
            state_reg <= ST_IDLE; // see RQ14
            tick_reg <= 8'h00;
        end else if (restart_reg) begin
            state_reg <= ST_SAMPLE; // see RQ11
            tick_reg <= sample_len - 8'h01;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    state_reg <= ST_SAMPLE; // see RQ5
                    tick_reg <= sample_len - 8'h01;
                end
                ST_SAMPLE: begin
                    if (tick_reg == 8'h00) begin
                        state_reg <= ST_CONVERT;
                        tick_reg <= bit_len - 8'h01;
                    end else begin
                        tick_reg <= tick_reg - 8'h01;
                    end
                end
                ST_CONVERT: begin
                    if (tick_reg != 8'h00) begin
                        tick_reg <= tick_reg - 8'h01;
                    end else if (sar_last) begin
                        state_reg <= ST_DONE;
                    end else begin
                        tick_reg <= bit_len - 8'h01;
                    end
                end
                ST_DONE: begin
                    state_reg <= ST_SAMPLE; // see RQ5
                    tick_reg <= sample_len - 8'h01;
                end
                default: begin
                    state_reg <= ST_IDLE;
                    tick_reg <= 8'h00;
                end
            endcase
        end
    end

    // Analog core drive
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            core_enable_reg <= 1'b0;
            core_chan_reg <= '0;
            core_sample_reg <= 1'b0;
        end else begin
            core_enable_reg <= csr_reg.on;
            core_chan_reg <= csr_reg.chan; // see RQ12
            core_sample_reg <= state_reg == ST_SAMPLE;
        end
    end

    // One driver for the whole struct; every field comes from a flip-flop
    assign core_out = {core_enable_reg, core_chan_reg, core_sample_reg, sar_code};

    // Comparator arrives from the analog domain
    adcc_sync u_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .async_in(cmp_above),
        .sync_out(above_sync)
    );

    // Bit decisions
    adcc_sar #(
        .W(RES_W)
    ) u_sar (
        .ref_clk(ref_clk),
        .reset(reset),
        .start(sar_start),
        .step(sar_step),
        .above(above_sync),
        .code(sar_code),
        .last(sar_last)
    );

    // Steps of one conversion
    sequence s_sample_end;
        state_reg == ST_SAMPLE && tick_reg == 8'h00 && csr_reg.on && !restart_reg;
    endsequence
    sequence s_last_bit;
        state_reg == ST_CONVERT && tick_reg == 8'h00 && sar_last && csr_reg.on && !restart_reg;
    endsequence

    a_done_flag_set: assert property (s_last_bit |=> ##1 (done_reg && result_reg == $past(sar_code))) // see RQ6
        else $error("completion did not set flag and result");
    a_sample_to_conv: assert property (s_sample_end |=> state_reg == ST_CONVERT && sar_code == 10'h200) // see RQ1
        else $error("conversion did not start at mid scale");
    a_hi_read_clear: assert property ((hi_rd && !conv_done) |=> !done_reg) // see RQ7
        else $error("high result read did not clear flag");
    a_csr_write_clear: assert property ((csr_wr && !conv_done) |=> !done_reg) // see RQ15
        else $error("control write did not clear flag");
    a_off_stops_conv: assert property (!csr_reg.on |=> state_reg == ST_IDLE) // see RQ14
        else $error("converter kept running while off");
    a_chan_restart: assert property ((chan_change && csr_reg.on && wdata_reg[CSR_ON_BIT])
        |=> ##1 (state_reg == ST_SAMPLE && tick_reg == sample_len - 8'h01)) // see RQ11
        else $error("channel change did not restart");
    a_on_starts_conv: assert property ((state_reg == ST_IDLE && csr_reg.on) |=> state_reg == ST_SAMPLE) // see RQ5
        else $error("turning on did not start sampling");
    a_result_stable: assert property (!conv_done |=> $stable(result_reg)) // see RQ8
        else $error("result changed without completion");
    a_mux_select: assert property (##1 core_out.chan == $past(csr_reg.chan)) // see RQ12
        else $error("multiplexer does not follow channel field");
endmodule : adcc_top

`default_nettype wire

// *** verif/adcc_core_model.sv ***
// Analog core stand-in: per-channel levels, sample-and-hold and comparator.
// Assumes the sequencer tracks while sample is high, then steps the trial code.
`timescale 1ns/1ps
`default_nettype none

module adcc_core_model
    import adcc_pkg::*;
(
    input wire logic ref_clk,
    input wire adcc_core_t core_out,
    input var int level [16], // Plain analog levels, no pull-up or interrupt
    output logic cmp_above
);
    int held; // Held sample of the selected input
    logic idle_bit = 1'h0; // Meaningless output while unpowered

    // Track the routed input while sampling
    always_ff @(posedge ref_clk) begin
        if (core_out.sample) begin
            held <= level[core_out.chan];
        end
        idle_bit <= ~idle_bit;
    end

    // Comparator: high while the held level reaches the trial code
    always_comb begin
        if (core_out.enable) begin
            cmp_above = (held >= int'(core_out.code));
        end else begin
            cmp_above = idle_bit; // Powered down, output toggles
        end
    end
endmodule : adcc_core_model

`default_nettype wire

// *** verif/adcc_top_tb.sv ***
// Self-checking bench for the converter control block.
// Assumes the analog core model in the same folder.
`timescale 1ns/1ps
`default_nettype none

module adcc_top_tb
    import adcc_pkg::*;
;
    localparam logic [11:0] A_CSR = {CSR_IDX, 2'b00};
    localparam logic [11:0] A_HI = {RES_HI_IDX, 2'b00};
    localparam logic [11:0] A_LO = {RES_LO_IDX, 2'b00};
    localparam logic [11:0] A_ST = {INT_STAT_IDX, 2'b00};
    localparam logic [11:0] A_MK = {INT_MASK_IDX, 2'b00};
    logic ref_clk = 1'h0;
    logic reset = 1'h1;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, irq, cmp;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, got;
    adcc_core_t core;
    int level [16];
    int fail_count = 0, total_checks = 0;

    // Free-running 50 MHz clock
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end

    adcc_top dut (.ref_clk(ref_clk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cmp_above(cmp),
        .core_out(core), .irq(irq));

    adcc_core_model far_end (.ref_clk(ref_clk), .core_out(core), .level(level), .cmp_above(cmp));

    // Verdict and end of run
    task automatic results;
        if (fail_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results

    // Register value compare
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    // Bus response compare
    task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
        chk({30'h0, g}, {30'h0, e});
    endtask : chk_resp

    // One clock with a bound on the whole wait
    task automatic tick(inout int n);
        @(posedge ref_clk);
        n++;
        if (n > 2000) begin
            fail_count++;
            results();
        end
    endtask : tick

    // Write: address and data offered together, each dropped when taken
    task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= 4'hf;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            tick(n);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'h0;
    endtask : wr

    // Read: address held until taken, data taken with rvalid
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            tick(n);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'h0;
    endtask : rd

    // Read expecting OKAY and a value
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        rd(a, got, resp);
        chk_resp(resp, RESP_OKAY);
        chk(got, e);
    endtask : rdc

    // Poll the completion flag, bounded
    task automatic wait_done;
        int n;
        n = 0;
        do begin
            rd(A_CSR, got, resp);
            tick(n);
        end while (got[CSR_DONE_BIT] !== 1'h1);
    endtask : wait_done

    // Clear status and flag, then wait for a completion that follows
    task automatic fresh_done(input logic [7:0] v);
        rd(A_ST, got, resp);
        wr(A_CSR, v, resp);
        wait_done;
    endtask : fresh_done

    // Reference code: clamp the level into the ten-bit range
    function automatic logic [9:0] conv(input int v);
        return (v < 0) ? 10'h0 : (v > 1023) ? 10'h3ff : 10'(v);
    endfunction : conv

    // Low then high, as a full-width reader does
    task automatic read_pair(input int v);
        logic [9:0] e;
        e = conv(v);
        rdc(A_LO, {30'h0, e[1:0]});
        rdc(A_HI, {24'h0, e[9:2]});
    endtask : read_pair

    initial begin
        void'($urandom(32'he72933c7));
        for (int i = 0; i < 16; i++) level[i] = 0;
        repeat (12) @(posedge ref_clk);
        reset <= 1'h0;
        rdc(A_CSR, 32'h0);
        rdc(A_HI, 32'h0);
        rdc(A_LO, 32'h0);
        chk({31'h0, core.enable}, 32'h0);
        wr(12'h200, 8'h01, resp);
        chk_resp(resp, RESP_SLVERR);
        rd(12'h200, got, resp);
        chk_resp(resp, RESP_SLVERR);
        // Every channel, switched mid-conversion, levels past both references
        for (int c = 0; c < 16; c++) begin
            level[c] <= (c == 0) ? 2000 : (c == 1) ? -50 : int'($urandom_range(1200)) - 80;
            wr(A_CSR, 8'h60 | 8'(c), resp);
            rdc(A_CSR, {24'h0, 8'h60 | 8'(c)});
            chk({28'h0, core.chan}, 32'(c));
            wait_done;
            read_pair(level[c]);
            rdc(A_CSR, {24'h0, 8'h60 | 8'(c)});
        end
        // Slow clock, unmasked interrupt, overwrite without result reads
        wr(A_MK, 8'h01, resp);
        level[15] <= 300;
        wr(A_CSR, 8'h2f, resp);
        wait_done;
        fresh_done(8'h2f);
        chk({31'h0, irq}, 32'h1);
        rdc(A_ST, 32'h1);
        repeat (2) @(posedge ref_clk);
        chk({31'h0, irq}, 32'h0);
        level[15] <= 900;
        wr(A_MK, 8'h00, resp);
        repeat (2) fresh_done(8'h2f);
        chk({31'h0, irq}, 32'h0);
        rdc(A_HI, 32'(10'd900 >> 2));
        rdc(A_CSR, 32'h2f);
        wait_done;
        wr(A_CSR, 8'h2f, resp);
        rdc(A_CSR, 32'h2f);
        wr(A_CSR, 8'h0f, resp);
        repeat (300) @(posedge ref_clk);
        rdc(A_CSR, 32'h0f);
        chk({31'h0, core.enable}, 32'h0);
        results();
    end
endmodule : adcc_top_tb

`default_nettype wire
